/* File: fem_pkg.sv */
// fault and event monitor: shared constants, codes and helper functions
// assumes a 125 MHz clock and analog values already digitised upstream
package fem_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_MS = 1;                   // base tick period, ms
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int PRESS_S = 5;                   // shortfall qualify time
   localparam int PRESS_TICKS = PRESS_S * 1000 / TICK_MS;
   localparam int SW_S = 5;                      // switch setting time
   localparam int SW1_TICKS = SW_S * 1000 / TICK_MS + 1;  // strictly more
   localparam int SW2_TICKS = SW_S * 1000 / TICK_MS;      // or longer
   localparam int KEY_S = 2;                     // key hold time
   localparam int KEY_TICKS = KEY_S * 1000 / TICK_MS;
   localparam int QUAL_W = 14;

   // ****************************************************************
   // thresholds (pressure and set-point in 0.1 %F.S. units)
   // ****************************************************************
   localparam logic [15:0] SUPPLY_MIN_MV = 16'd19500;  // 19.5 V
   localparam logic [12:0] FULL_SCALE = 13'd1000;
   localparam logic [12:0] SP_LIMIT = 13'd1100;        // 110 %F.S.
   localparam logic [12:0] PRESS_GAP = 13'd200;        // 20 %F.S.
   localparam logic [12:0] SW_GAP = 13'd10;

   // ****************************************************************
   // event indices: 0..4 errors, 5..9 warnings
   // ****************************************************************
   localparam int EVT_N = 10;
   localparam int EV_SUPPLY = 0;
   localparam int EV_INPUT = 1;
   localparam int EV_NVM = 2;
   localparam int EV_ROM = 3;
   localparam int EV_PRESS = 4;
   localparam int EV_VSUP = 5;
   localparam int EV_VEXH = 6;
   localparam int EV_SW1 = 7;
   localparam int EV_SW2 = 8;
   localparam int EV_TEMP = 9;

   // ****************************************************************
   // register map (byte offsets) and reset values
   // ****************************************************************
   localparam logic [7:0] REG_STATUS = 8'h00;   // sticky, write 1 clears
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_ACTIVE = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;
   localparam logic [9:0] MASK_RST = 10'h000;
   localparam int ACT_RUN_BIT = 16;
   localparam int ACT_ENTRY_BIT = 17;
   localparam int ACT_ZERO_BIT = 18;
   localparam int CTRL_CLR_BIT = 0;

   // 16-bit event code per index
   function automatic logic [15:0] fem_code(input logic [3:0] i);
      case (i)
         4'h0: fem_code = 16'h8D02;
         4'h1: fem_code = 16'h8D03;
         4'h2: fem_code = 16'h8D04;
         4'h3: fem_code = 16'h8D05;
         4'h4: fem_code = 16'h8D06;
         4'h5: fem_code = 16'h8D10;
         4'h6: fem_code = 16'h8D11;
         4'h7: fem_code = 16'h8D12;
         4'h8: fem_code = 16'h8D13;
         4'h9: fem_code = 16'h4210;
         default: fem_code = 16'h0000;
      endcase
   endfunction : fem_code

   // panel code number per index (E nn)
   function automatic logic [7:0] fem_disp(input logic [3:0] i);
      case (i)
         4'h0: fem_disp = 8'h02;
         4'h1: fem_disp = 8'h05;
         4'h2: fem_disp = 8'h03;
         4'h3: fem_disp = 8'h04;
         4'h4: fem_disp = 8'h06;
         4'h5: fem_disp = 8'h10;
         4'h6: fem_disp = 8'h11;
         4'h7: fem_disp = 8'h12;
         4'h8: fem_disp = 8'h13;
         4'h9: fem_disp = 8'h14;
         default: fem_disp = 8'h00;
      endcase
   endfunction : fem_disp

   // lowest set index of an event vector
   function automatic logic [3:0] fem_first(input logic [9:0] v);
      fem_first = 4'hF;
      for (int k = EVT_N - 1; k >= 0; k--) begin
         if (v[k]) fem_first = 4'(k);
      end
   endfunction : fem_first

endpackage : fem_pkg

/* File: fem_qual.sv */
// duration qualifier: output rises once cond held for limit ticks
// assumes tick is a one-cycle enable from the block's divider
`timescale 1ns/1ps
module fem_qual
   import fem_pkg::*;
#(
   parameter int W = QUAL_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // qualify inputs
   input wire logic tick,
   input wire logic cond,
   input wire logic [W-1:0] limit,
   // result
   output logic qual
);
   logic [W-1:0] cnt_q, cnt_d;
   logic qual_q, qual_d;

   if (W < 2) begin : g_bad
      $error("fem_qual: counter too narrow");
   end

   // count ticks while cond holds, restart as soon as it drops
   always_comb begin
      cnt_d = cnt_q;
      qual_d = qual_q;
      if (!cond) begin
         cnt_d = '0;
         qual_d = 1'b0;
      end else if (tick && cnt_q != limit) begin
         cnt_d = cnt_q + W'(1);
         qual_d = (cnt_q + W'(1)) == limit;
      end
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         qual_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         qual_q <= qual_d;
      end
   end

   assign qual = qual_q;
endmodule : fem_qual

/* File: fem_toggle.sv */
// valve overactivity detector: counts real on/off cycles per window
// assumes drive is the valve's synchronous on level
`timescale 1ns/1ps
module fem_toggle #(
   parameter int MIN_ON = 125,    // shortest on pulse that counts, cycles
   parameter int WIN_TICKS = 1000,
   parameter int N_TOG = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // drive sample
   input wire logic tick,
   input wire logic drive,
   // result
   output logic over
);
   logic [11:0] on_q, on_d;
   logic [11:0] tog_q, tog_d;
   logic [11:0] win_q, win_d;
   logic drv_q, drv_d;
   logic over_q, over_d;

   if (MIN_ON < 1 || MIN_ON > 4095 || WIN_TICKS < 1 || WIN_TICKS > 4095
       || N_TOG < 1 || N_TOG > 4095) begin : g_bad
      $error("fem_toggle: parameter out of range");
   end

   // R15 repeated cycles only
   always_comb begin
      drv_d = drive;
      on_d = on_q;
      tog_d = tog_q;
      win_d = win_q;
      over_d = over_q;
      if (drive && on_q != 12'(MIN_ON)) on_d = on_q + 12'h001;
      if (!drive) on_d = 12'h000;
      // an on pulse ending after min length is one cycle; steady on is none
      if (drv_q && !drive && on_q == 12'(MIN_ON) && tog_q != 12'hFFF) begin
         tog_d = tog_q + 12'h001;
      end
      if (tick) begin
         if (win_q == 12'(WIN_TICKS - 1)) begin
            win_d = 12'h000;
            over_d = tog_d >= 12'(N_TOG);
            tog_d = 12'h000;
         end else begin
            win_d = win_q + 12'h001;
         end
      end
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_q <= 1'b0;
         on_q <= 12'h000;
         tog_q <= 12'h000;
         win_q <= 12'h000;
         over_q <= 1'b0;
      end else begin
         drv_q <= drv_d;
         on_q <= on_d;
         tog_q <= tog_d;
         win_q <= win_d;
         over_q <= over_d;
      end
   end

   assign over = over_q;
endmodule : fem_toggle

/* File: fem_monitor.sv */
// fault and warning supervisor of a pressure regulator, APB slave top
// assumes all inputs synchronous to pclk; events leave by valid/ready
// Function
// R1: low supply flags error, control runs
// R2: set-point over 110% errors and clamps
// R3: memory failures raise events, halt control
// R4: 20% shortfall for 5 s errors
// R5: supply valve overactive warns, no display
// R6: exhaust valve overactive warns, no display
// R7: switch 1 bad window over 5 s
// R8: switch 2 bad window 5 s or more
// R9: hot link driver warns
// R10: any error sets error flag
// R11: any warning sets warning flag
// R12: set-point error cleared by link command
// R13: two keys 2 s enter entry screen
// R14: set key 2 s zeroes, clears error
// R15: overactive means repeated real on/off cycles
// R16: each event reported once, flag held
// R17: duration counters restart on dropout
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fem_monitor
   import fem_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int PRESS_T = PRESS_TICKS,
   parameter int SW1_T = SW1_TICKS,
   parameter int SW2_T = SW2_TICKS,
   parameter int KEY_T = KEY_TICKS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // measured plant values
   input wire logic [15:0] supply_mv,
   input wire logic [11:0] sp_in,
   input wire logic [11:0] press_fb,
   input wire logic nvm_fail,
   input wire logic rom_fail,
   input wire logic valve_sup,
   input wire logic valve_exh,
   input wire logic drv_hot,
   // switch output settings
   input wire logic sw1_window,
   input wire logic [11:0] sw1_lo,
   input wire logic [11:0] sw1_hi,
   input wire logic sw2_window,
   input wire logic [11:0] sw2_lo,
   input wire logic [11:0] sw2_hi,
   // panel keys and link command
   input wire logic preset_en,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic key_set,
   input wire logic link_clr_sp,
   // control and panel outputs
   output logic [11:0] sp_eff,
   output logic ctrl_run,
   output logic seg_en,
   output logic [7:0] disp_code,
   output logic entry_screen,
   // process data flags and events
   output logic err_flag,
   output logic warn_flag,
   output logic evt_valid,
   output logic [15:0] evt_code,
   input wire logic evt_ready,
   output logic irq
);
   typedef enum logic [0:0] {FEM_K_IDLE, FEM_K_ENTRY} fem_key_e;

   if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << 20) || PRESS_T < 1 ||
       SW1_T < 1 || SW2_T < 1 || KEY_T < 1 || PRESS_T >= (1 << QUAL_W) ||
       SW1_T >= (1 << QUAL_W) || SW2_T >= (1 << QUAL_W) ||
       KEY_T >= (1 << QUAL_W)) begin : g_bad
      $error("fem_monitor: timing parameter out of range");
   end

   // ****************************************************************
   // millisecond tick divider
   // ****************************************************************
   logic [19:0] div_q, div_d;
   logic tick;

   always_comb begin
      tick = div_q == 20'(TICK_CYCLES - 1);
      div_d = tick ? 20'h0_0000 : div_q + 20'h0_0001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_q <= 20'h0_0000;
      else div_q <= div_d;
   end

   // ****************************************************************
   // condition detection
   // ****************************************************************
   logic [9:0] act, act_q;
   logic inerr_q, inerr_d, zero_q, zero_d, nvm_q, rom_q, mem_d_n, mem_d_r;
   logic [11:0] sp_q, sp_d;
   logic short_c, press_ok, sw1_c, sw2_c, sw1_ok, sw2_ok;
   logic vsup_ok, vexh_ok, both_c, set_c, both_ok, set_ok;
   logic key_clr, sw_clr, clr_sp;
   fem_key_e key_q, key_d;

   // R4 shortfall compare
   assign short_c = ({1'b0, press_fb} + PRESS_GAP) <= {1'b0, sp_q};
   // R7 lower above upper minus gap
   assign sw1_c = sw1_window && ({1'b0, sw1_lo} + SW_GAP) > {1'b0, sw1_hi};
   // R8 same check, second output
   assign sw2_c = sw2_window && ({1'b0, sw2_lo} + SW_GAP) > {1'b0, sw2_hi};
   assign both_c = key_q == FEM_K_IDLE && preset_en && inerr_q &&
                   key_up && key_down;
   assign set_c = key_q == FEM_K_ENTRY && key_set;

   // R17 restarting duration counters
   fem_qual u_press (.pclk(pclk), .presetn(presetn), .tick(tick),
      .cond(short_c), .limit(QUAL_W'(PRESS_T)), .qual(press_ok));
   fem_qual u_sw1 (.pclk(pclk), .presetn(presetn), .tick(tick),
      .cond(sw1_c), .limit(QUAL_W'(SW1_T)), .qual(sw1_ok));
   fem_qual u_sw2 (.pclk(pclk), .presetn(presetn), .tick(tick),
      .cond(sw2_c), .limit(QUAL_W'(SW2_T)), .qual(sw2_ok));
   fem_qual u_both (.pclk(pclk), .presetn(presetn), .tick(tick),
      .cond(both_c), .limit(QUAL_W'(KEY_T)), .qual(both_ok));
   fem_qual u_set (.pclk(pclk), .presetn(presetn), .tick(tick),
      .cond(set_c), .limit(QUAL_W'(KEY_T)), .qual(set_ok));

   // R5 supply valve watch, R6 exhaust valve watch
   fem_toggle u_vsup (.pclk(pclk), .presetn(presetn), .tick(tick),
      .drive(valve_sup), .over(vsup_ok));
   fem_toggle u_vexh (.pclk(pclk), .presetn(presetn), .tick(tick),
      .drive(valve_exh), .over(vexh_ok));

   // R13 key hold entry screen, R14 set hold clears
   always_comb begin
      key_d = key_q;
      key_clr = 1'b0;
      case (key_q)
         FEM_K_IDLE: if (both_ok) key_d = FEM_K_ENTRY;
         FEM_K_ENTRY: begin
            if (set_ok) begin
               key_clr = 1'b1;
               key_d = FEM_K_IDLE;
            end else if (!preset_en) begin
               key_d = FEM_K_IDLE;
            end
         end
         default: key_d = FEM_K_IDLE;
      endcase
   end

   // set-point error, zeroing, clamp and memory latches
   always_comb begin
      clr_sp = key_clr || link_clr_sp || sw_clr;
      // R12 clear request, new excursion wins
      inerr_d = (inerr_q && !clr_sp) || ({1'b0, sp_in} > SP_LIMIT);
      // R14 zero held until the input is back within full scale
      zero_d = key_clr || (zero_q && {1'b0, sp_in} > FULL_SCALE);
      // R2 clamp at 110 %F.S.
      if (zero_q) sp_d = 12'h000;
      else if ({1'b0, sp_in} > SP_LIMIT) sp_d = SP_LIMIT[11:0];
      else sp_d = sp_in;
      // R3 memory faults latch until reset
      mem_d_n = nvm_q || nvm_fail;
      mem_d_r = rom_q || rom_fail;
      act = 10'h000;
      // R1 supply at or below threshold
      act[EV_SUPPLY] = supply_mv <= SUPPLY_MIN_MV;
      act[EV_INPUT] = inerr_q;
      act[EV_NVM] = nvm_q;
      act[EV_ROM] = rom_q;
      act[EV_PRESS] = press_ok;
      act[EV_VSUP] = vsup_ok;
      act[EV_VEXH] = vexh_ok;
      act[EV_SW1] = sw1_ok;
      act[EV_SW2] = sw2_ok;
      // R9 driver temperature
      act[EV_TEMP] = drv_hot;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= FEM_K_IDLE;
         inerr_q <= 1'b0;
         zero_q <= 1'b0;
         sp_q <= 12'h000;
         nvm_q <= 1'b0;
         rom_q <= 1'b0;
         act_q <= 10'h000;
      end else begin
         key_q <= key_d;
         inerr_q <= inerr_d;
         zero_q <= zero_d;
         sp_q <= sp_d;
         nvm_q <= mem_d_n;
         rom_q <= mem_d_r;
         act_q <= act;
      end
   end

   // ****************************************************************
   // flags, panel and event reporting
   // ****************************************************************
   logic [9:0] rise, pend_q, pend_d, take;
   logic [3:0] nxt;
   logic cur_q, cur_d, errf_q, errf_d, warnf_q, warnf_d, run_q, run_d;
   logic seg_q, seg_d;
   logic [15:0] code_q, code_d;
   logic [7:0] disp_q, disp_d;

   always_comb begin
      rise = act & ~act_q;
      // R10 error flag, R11 warning flag
      errf_d = |act_q[EV_PRESS:EV_SUPPLY];
      warnf_d = |act_q[EV_TEMP:EV_VSUP];
      // R3 control halts only on memory faults
      run_d = !(nvm_q || rom_q);
      // R5 R6 warnings never light the display
      seg_d = errf_d;
      disp_d = fem_disp(fem_first(act_q));
      // R16 one report per rising condition
      nxt = fem_first(pend_q);
      take = 10'h000;
      cur_d = cur_q && !evt_ready;
      code_d = code_q;
      if (!cur_d && |pend_q) begin
         cur_d = 1'b1;
         code_d = fem_code(nxt);
         take[nxt] = 1'b1;
      end
      pend_d = (pend_q & ~take) | rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 10'h000;
         cur_q <= 1'b0;
         code_q <= 16'h0000;
         errf_q <= 1'b0;
         warnf_q <= 1'b0;
         run_q <= 1'b1;
         seg_q <= 1'b0;
         disp_q <= 8'h00;
      end else begin
         pend_q <= pend_d;
         cur_q <= cur_d;
         code_q <= code_d;
         errf_q <= errf_d;
         warnf_q <= warnf_d;
         run_q <= run_d;
         seg_q <= seg_d;
         disp_q <= disp_d;
      end
   end

   // ****************************************************************
   // apb register file and interrupt
   // ****************************************************************
   logic [9:0] sts_q, sts_d, mask_q, mask_d;
   logic [31:0] rd_q, rd_d;
   logic err_q, err_d, wr_acc, mapped;

   always_comb begin
      mapped = paddr == REG_STATUS || paddr == REG_MASK ||
               paddr == REG_ACTIVE || paddr == REG_CTRL;
      wr_acc = psel && penable && pwrite && mapped;
      sts_d = sts_q;
      mask_d = mask_q;
      sw_clr = 1'b0;
      if (wr_acc && paddr == REG_STATUS) sts_d = sts_q & ~pwdata[9:0];
      if (wr_acc && paddr == REG_MASK) mask_d = pwdata[9:0];
      // R12 software clear of the set-point error
      if (wr_acc && paddr == REG_CTRL) sw_clr = pwdata[CTRL_CLR_BIT];
      sts_d = sts_d | rise;
      rd_d = rd_q;
      err_d = err_q;
      if (psel && !penable) begin
         err_d = !mapped;
         rd_d = 32'h0000_0000;
         case (paddr)
            REG_STATUS: rd_d[9:0] = sts_q;
            REG_MASK: rd_d[9:0] = mask_q;
            REG_ACTIVE: begin
               rd_d[9:0] = act_q;
               rd_d[ACT_RUN_BIT] = run_q;
               rd_d[ACT_ENTRY_BIT] = key_q == FEM_K_ENTRY;
               rd_d[ACT_ZERO_BIT] = zero_q;
            end
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= 10'h000;
         mask_q <= MASK_RST;
         rd_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else begin
         sts_q <= sts_d;
         mask_q <= mask_d;
         rd_q <= rd_d;
         err_q <= err_d;
      end
   end

   // outputs
   assign prdata = rd_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_q;
   assign irq = |(sts_q & mask_q);
   assign sp_eff = sp_q;
   assign ctrl_run = run_q;
   assign seg_en = seg_q;
   assign disp_code = disp_q;
   assign entry_screen = key_q == FEM_K_ENTRY;
   assign err_flag = errf_q;
   assign warn_flag = warnf_q;
   assign evt_valid = cur_q;
   assign evt_code = code_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence low_supply_s;
      (supply_mv <= SUPPLY_MIN_MV) [*2];
   endsequence

   supply_err_a: assert property (low_supply_s |=> err_flag); // R1
      else $error("supply error flag missing");
   clamp_sp_a: assert property (({1'b0, sp_in} > SP_LIMIT && !zero_q) // R2
      |=> sp_eff == SP_LIMIT[11:0]) else $error("set-point not clamped");
   mem_halt_a: assert property ((nvm_fail || rom_fail) // R3
      |=> ##1 !ctrl_run [*3]) else $error("control not halted");
   press_drop_a: assert property (!short_c |-> ##2 !act_q[EV_PRESS]) // R17
      else $error("shortfall flag outlived condition");
   warn_only_a: assert property (act_q[EV_TEMP] && !(|act_q[4:0]) // R11
      |=> warn_flag && !seg_en) else $error("warning flag wrong");
   err_flag_a: assert property (!(|act_q[4:0]) |=> !err_flag) // R10
      else $error("error flag without error");
   evt_hold_a: assert property (evt_valid && !evt_ready // R16
      |=> evt_valid && $stable(evt_code)) else $error("event dropped");
   key_zero_a: assert property (key_clr // R14
      |=> ##1 sp_eff == 12'h000) else $error("set pressure not zeroed");
   entry_cause_a: assert property ($rose(entry_screen) // R13
      |-> $past(both_ok) && $past(inerr_q)) else $error("bad entry");
endmodule : fem_monitor

/* File: fem_link_master.sv */
// link master model: takes event codes from the monitor
// assumes codes stand until taken at a rising edge
`timescale 1ns/1ps
module fem_link_master (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pacing
   input wire logic slow,
   // event stream
   input wire logic evt_valid,
   input wire logic [15:0] evt_code,
   output logic evt_ready,
   // last code taken
   output logic [15:0] last_code
);
   logic [1:0] div_q;
   // one code per handshake, stalls when slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 2'h0;
         last_code <= 16'h0000;
      end else begin
         div_q <= div_q + 2'h1;
         if (evt_valid && evt_ready) begin
            last_code <= evt_code;
         end
      end
   end
   // ready only one cycle in four while slow
   assign evt_ready = !slow || (div_q == 2'h3);
endmodule : fem_link_master

/* File: testbench.sv */
// testbench: apb access and plant stimulus for the monitor
// assumes short tick and qualify counts set below
`timescale 1ns/1ps
module testbench;
   import fem_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd_v;
   logic pready, pslverr, err_v, slow = 0;
   logic [15:0] supply_mv = 16'h5DC0, evt_code, last_code;
   logic [11:0] sp_in = 12'h1F4, press_fb = 12'h1F4, sp_eff;
   logic nvm_fail = 0, drv_hot = 0, link_clr_sp = 0, preset_en = 0;
   logic rom_fail = 0, valve_sup = 0, valve_exh = 0;
   logic key_up = 0, key_down = 0, key_set = 0, sw1_window = 0;
   logic sw2_window = 0;
   logic [11:0] sw1_lo = 0, sw1_hi = 0, sw2_lo = 0, sw2_hi = 0;
   logic ctrl_run, seg_en, entry_screen, err_flag, warn_flag;
   logic evt_valid, evt_ready, irq;
   logic [7:0] disp_code;
   int mismatches = 0, total_checks = 0, cycles = 0;
   always #4 pclk = ~pclk;
   fem_monitor #(.TICK_CYCLES(4), .PRESS_T(5), .SW1_T(6), .SW2_T(5),
      .KEY_T(3)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .supply_mv(supply_mv), .sp_in(sp_in),
      .press_fb(press_fb), .nvm_fail(nvm_fail), .rom_fail(rom_fail),
      .valve_sup(valve_sup), .valve_exh(valve_exh), .drv_hot(drv_hot),
      .sw1_window(sw1_window), .sw1_lo(sw1_lo), .sw1_hi(sw1_hi),
      .sw2_window(sw2_window), .sw2_lo(sw2_lo), .sw2_hi(sw2_hi),
      .preset_en(preset_en), .key_up(key_up), .key_down(key_down),
      .key_set(key_set), .link_clr_sp(link_clr_sp), .sp_eff(sp_eff),
      .ctrl_run(ctrl_run), .seg_en(seg_en), .disp_code(disp_code),
      .entry_screen(entry_screen), .err_flag(err_flag),
      .warn_flag(warn_flag), .evt_valid(evt_valid),
      .evt_code(evt_code), .evt_ready(evt_ready), .irq(irq));
   fem_link_master lm (.pclk(pclk), .presetn(presetn), .slow(slow),
      .evt_valid(evt_valid), .evt_code(evt_code),
      .evt_ready(evt_ready), .last_code(last_code));
   // ******************************
   // tasks
   // ******************************
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // both valves switched on for on_c cycles and off for 10, n times
   task valves(input int n, input int on_c);
      repeat (n) begin
         valve_sup <= 1'b1;
         valve_exh <= 1'b1;
         wt(on_c);
         valve_sup <= 1'b0;
         valve_exh <= 1'b0;
         wt(10);
      end
   endtask : valves
   // apb transfer, held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run;
      end
   end
   // ******************************
   // scenarios
   // ******************************
   initial begin
      wt(16);
      presetn <= 1'b1;
      chk("run", 1, ctrl_run);
      apb(0, REG_MASK, 0);
      chk("mask", 0, rd_v);
      apb(0, 8'h10, 0);
      chk("slverr", 1, err_v);
      apb(1, REG_MASK, 32'h0000_0200);
      drv_hot <= 1'b1;
      wt(6);
      chk("warn", 1, warn_flag);
      chk("irq", 1, irq);
      chk("code", 16'h4210, last_code);
      chk("seg", 0, seg_en);
      drv_hot <= 1'b0;
      wt(4);
      apb(1, REG_STATUS, 32'h0000_0200);
      chk("irq clr", 0, irq);
      chk("warn off", 0, warn_flag);
      slow <= 1'b1;
      supply_mv <= 16'h4C2C;
      wt(12);
      chk("err", 1, err_flag);
      chk("code", 16'h8D02, last_code);
      chk("run", 1, ctrl_run);
      supply_mv <= 16'h5DC0;
      slow <= 1'b0;
      sp_in <= 12'h4B0;
      wt(8);
      chk("clamp", 12'h44C, sp_eff);
      chk("code", 16'h8D03, last_code);
      chk("disp", 8'h05, disp_code);
      sp_in <= 12'h1F4;
      link_clr_sp <= 1'b1;  // link clear command
      wt(1);
      link_clr_sp <= 1'b0;
      wt(4);
      chk("link clr", 0, err_flag);
      sp_in <= 12'h4B0;
      wt(4);
      sp_in <= 12'h1F4;
      apb(1, REG_CTRL, 32'h0000_0001);
      wt(2);
      chk("ctrl clr", 0, err_flag);
      preset_en <= 1'b1;
      sp_in <= 12'h4B0;
      wt(4);
      key_up <= 1'b1;
      key_down <= 1'b1;
      wt(18);
      chk("entry", 1, entry_screen);
      key_up <= 1'b0;
      key_down <= 1'b0;
      sp_in <= 12'h41A;
      key_set <= 1'b1;
      wt(18);
      key_set <= 1'b0;
      wt(3);
      chk("zero", 0, sp_eff);
      chk("key clr", 0, err_flag);
      sp_in <= 12'h1F4;
      press_fb <= 12'h0FA;
      wt(12);
      press_fb <= 12'h1F4;
      wt(4);
      press_fb <= 12'h0FA;
      wt(12);
      chk("restart", 0, err_flag);
      wt(16);
      chk("short", 1, err_flag);
      chk("code", 16'h8D06, last_code);
      press_fb <= 12'h1F4;
      sw1_window <= 1'b1;
      sw2_window <= 1'b1;
      sw1_lo <= 12'h064;
      sw1_hi <= 12'h064;
      sw2_lo <= 12'h064;
      sw2_hi <= 12'h064;
      wt(40);
      apb(0, REG_ACTIVE, 0);
      chk("sw act", 32'h0001_0180, rd_v & 32'h0001_0180);
      chk("sw warn", 1, warn_flag);
      // short on pulses over two windows must stay quiet
      valves(120, 60);
      apb(0, REG_STATUS, 0);
      chk("short on", 0, rd_v & 32'h0000_0060);
      // long on/off cycles over two windows are overactive
      valves(60, 130);
      apb(0, REG_ACTIVE, 0);
      chk("valve act", 32'h0000_0060, rd_v & 32'h0000_0060);
      chk("valve seg", 0, seg_en);
      chk("valve run", 1, ctrl_run);
      chk("code", 16'h8D11, last_code);
      nvm_fail <= 1'b1;
      wt(1);
      nvm_fail <= 1'b0;
      wt(6);
      chk("halt", 0, ctrl_run);
      chk("code", 16'h8D04, last_code);
      chk("valid", 0, evt_valid);
      // mid-run reset clears the memory latch
      presetn <= 1'b0;
      wt(2);
      presetn <= 1'b1;
      wt(1);
      chk("run rst", 1, ctrl_run);
      rom_fail <= 1'b1;
      wt(1);
      rom_fail <= 1'b0;
      wt(6);
      chk("halt rom", 0, ctrl_run);
      chk("code", 16'h8D05, last_code);
      complete_run;
   end
endmodule : testbench
